//--- shared/ctdp_pkg.sv
package ctdp_pkg;
    // ---------------------------------------------------------------
    // Register map (word aligned byte offsets)
    // ---------------------------------------------------------------
    localparam logic [7:0] CTDP_REG_CTRL = 8'h00;
    localparam logic [7:0] CTDP_REG_FLAGS = 8'h04;
    localparam logic [7:0] CTDP_REG_OPWORD = 8'h08;
    localparam logic [7:0] CTDP_REG_COND = 8'h0c;
    localparam logic [7:0] CTDP_REG_EA = 8'h10;
    localparam logic [7:0] CTDP_REG_RESULT = 8'h14;
    localparam logic [7:0] CTDP_REG_PFQ = 8'h18;
    localparam logic [7:0] CTDP_REG_PC = 8'h1c;
    localparam logic [7:0] CTDP_REG_IWORD = 8'h20;
    localparam logic [7:0] CTDP_REG_FETCHCNT = 8'h24;

    // Control register bits (bits 0-3: write 1 to act, self clearing; bits 4-5 load sr_ok_r and move_r)
    localparam int CTDP_CTRL_CONSUME_EXT = 0;
    localparam int CTDP_CTRL_NEXT_INSTR = 1;
    localparam int CTDP_CTRL_FLUSH = 2;
    localparam int CTDP_CTRL_FLAG_UPD = 3;
    localparam int CTDP_CTRL_SR_OK = 4;
    localparam int CTDP_CTRL_MOVE = 5;

    // Flag positions: X N Z V C
    localparam int CTDP_F_C = 0;
    localparam int CTDP_F_V = 1;
    localparam int CTDP_F_Z = 2;
    localparam int CTDP_F_N = 3;
    localparam int CTDP_F_X = 4;

    // Reset values
    localparam logic [4:0] CTDP_FLAGS_RST = 5'h00;
    localparam logic [31:0] CTDP_PC_RST = 32'h0000_0000;
    localparam logic [15:0] CTDP_WORD_RST = 16'h0000;

    // Instruction groups (top four opcode bits)
    localparam logic [3:0] CTDP_GRP_QUICK_SET = 4'h5;
    localparam logic [3:0] CTDP_GRP_BRANCH = 4'h6;

    // Sizes
    typedef enum logic [1:0] {
        CTDP_SZ_BYTE = 2'h0,
        CTDP_SZ_WORD = 2'h1,
        CTDP_SZ_LONG = 2'h2,
        CTDP_SZ_OTHER = 2'h3
    } ctdp_size_t;

    // Prefetch states, Gray coded along the usual path
    typedef enum logic [1:0] {
        CTDP_PF_EMPTY = 2'b00,
        CTDP_PF_ONE = 2'b01,
        CTDP_PF_FULL = 2'b11
    } ctdp_pf_t;
endpackage

//--- src/ctdp_core.sv
// Overview of operation
// RULE1: Condition result is one bit; one means holds, zero means fails.
// RULE2: Code 0000 always true, code 0001 always false.
// RULE3: 0111 true when zero set; 0110 true when zero clear.
// RULE4: 0010 true with carry and zero clear; 0011 when either set.
// RULE5: 0100/0101 carry clear/set, 1000/1001 overflow, 1010/1011 negative.
// RULE6: 1100 true when negative equals overflow; 1101 when they differ.
// RULE7: 1111 zero or N differs from V; 1110 is its complement.
// RULE8: General update: extend copies carry, N is result msb, Z if all zero.
// RULE9: Classify each mode as data, memory, alterable, control.
// RULE10: Combined categories are intersections of their parts.
// RULE11: Modes 000 to 110 use register field as register number.
// RULE12: Mode 111 register field picks abs short, long, PC disp, index, immediate.
// RULE13: Category table membership per mode, immediate is data and memory only.
// RULE14: Status register addressing illegal unless explicitly permitted.
// RULE15: Two-word prefetch; opcode in decoder, next word already fetched.
// RULE16: Each consumed extension word triggers one refill fetch.
// RULE17: Last fetch happens when opcode discarded and next decode begins.
// RULE18: Taken short branch wasted a fetch; exceptions discard both words.
// RULE19: PC holds address of most recently fetched stream word.
// RULE20: General size field: 00 byte, 01 word, 10 long, 11 other op.
// RULE21: Move size field: 01 byte, 10 long, 11 word.
// RULE22: Conditional set writes all ones when true, zeros otherwise, flags kept.
// RULE23: Condition evaluation combinational on registered flags.
// RULE24: Top four opcode bits select group; 0110 branch, 0101 quick/set.
module ctdp_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic ifetch_req_o,
    output logic [31:0] ifetch_adr_o,
    input wire logic ifetch_ack_i,
    input wire logic [15:0] ifetch_dat_i
);
    import ctdp_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic cond_eval(input logic [3:0] cc, input logic [4:0] f);
        logic n;
        logic z;
        logic v;
        logic c;
        n = f[CTDP_F_N];
        z = f[CTDP_F_Z];
        v = f[CTDP_F_V];
        c = f[CTDP_F_C];
        case (cc)
            4'h0: cond_eval = 1'b1;              // [RULE2]
            4'h1: cond_eval = 1'b0;              // [RULE2]
            4'h2: cond_eval = !c && !z;          // [RULE4]
            4'h3: cond_eval = c || z;            // [RULE4]
            4'h4: cond_eval = !c;                // [RULE5]
            4'h5: cond_eval = c;                 // [RULE5]
            4'h6: cond_eval = !z;                // [RULE3]
            4'h7: cond_eval = z;                 // [RULE3]
            4'h8: cond_eval = !v;                // [RULE5]
            4'h9: cond_eval = v;                 // [RULE5]
            4'ha: cond_eval = !n;                // [RULE5]
            4'hb: cond_eval = n;                 // [RULE5]
            4'hc: cond_eval = n == v;            // [RULE6]
            4'hd: cond_eval = n != v;            // [RULE6]
            4'he: cond_eval = !z && (n == v);    // [RULE7]
            default: cond_eval = z || (n != v);  // [RULE7]
        endcase
    endfunction

    // Returns {data, memory, control, alterable}
    function automatic logic [3:0] ea_class(input logic [2:0] md, input logic [2:0] rg);
        case (md)
            3'h0: ea_class = 4'b1001;                          // [RULE13]
            3'h1: ea_class = 4'b0001;                          // [RULE13]
            3'h2, 3'h5, 3'h6: ea_class = 4'b1111;              // [RULE9]
            3'h3, 3'h4: ea_class = 4'b1101;                    // [RULE13]
            default: begin
                case (rg)
                    3'h0, 3'h1: ea_class = 4'b1111;            // [RULE12]
                    3'h2, 3'h3: ea_class = 4'b1110;            // [RULE13]
                    3'h4: ea_class = 4'b1100;                  // [RULE13]
                    default: ea_class = 4'b0000;
                endcase
            end
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Software-visible state
    // ---------------------------------------------------------------
    logic [4:0] flags_r;
    logic [15:0] opword_r;
    logic [31:0] result_r;
    logic carry_in_r;
    logic sr_ok_r;
    logic move_r;
    logic bus_hit;
    logic wr_en;

    assign bus_hit = cyc_i && stb_i && !ack_o;
    assign wr_en = bus_hit && we_i;

    logic ctl_wr;
    logic ext_pulse;
    logic next_pulse;
    logic flush_pulse;
    logic upd_pulse;
    assign ctl_wr = wr_en && adr_i == CTDP_REG_CTRL && sel_i[0];
    assign ext_pulse = ctl_wr && dat_i[CTDP_CTRL_CONSUME_EXT];
    assign next_pulse = ctl_wr && dat_i[CTDP_CTRL_NEXT_INSTR];
    assign flush_pulse = ctl_wr && dat_i[CTDP_CTRL_FLUSH];
    assign upd_pulse = ctl_wr && dat_i[CTDP_CTRL_FLAG_UPD];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sr_ok_r <= 1'b0;
            move_r <= 1'b0;
        end else if (ctl_wr) begin
            sr_ok_r <= dat_i[CTDP_CTRL_SR_OK];
            move_r <= dat_i[CTDP_CTRL_MOVE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opword_r <= CTDP_WORD_RST;
        end else if (wr_en && adr_i == CTDP_REG_OPWORD) begin
            opword_r <= dat_i[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_r <= 32'h0000_0000;
            carry_in_r <= 1'b0;
        end else if (wr_en && adr_i == CTDP_REG_RESULT) begin
            result_r <= dat_i;
        end else if (wr_en && adr_i == CTDP_REG_COND) begin
            carry_in_r <= dat_i[8];
        end
    end

    // Flags: direct write, or general-case update from the result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= CTDP_FLAGS_RST;
        end else if (upd_pulse) begin
            flags_r[CTDP_F_X] <= carry_in_r;             // [RULE8]
            flags_r[CTDP_F_C] <= carry_in_r;
            flags_r[CTDP_F_N] <= result_r[31];           // [RULE8]
            flags_r[CTDP_F_Z] <= result_r == 32'h0;      // [RULE8]
            flags_r[CTDP_F_V] <= 1'b0;
        end else if (wr_en && adr_i == CTDP_REG_FLAGS) begin
            flags_r <= dat_i[4:0];
        end
    end

    // ---------------------------------------------------------------
    // Decode, combinational on registered state
    // ---------------------------------------------------------------
    logic cond_ok;
    logic [3:0] grp;
    logic is_set;
    logic is_branch;
    logic [3:0] cls;
    logic sr_mode;
    logic ea_legal;
    logic [2:0] ea_reg;
    logic [2:0] ea_sub;
    logic [1:0] sz_code;
    logic [7:0] set_byte;

    // Condition field sits in bits 11:8 for both branch and set forms
    assign cond_ok = cond_eval(opword_r[11:8], flags_r);            // [RULE1] [RULE23]
    assign grp = opword_r[15:12];                                   // [RULE24]
    assign is_branch = grp == CTDP_GRP_BRANCH;                      // [RULE24]
    assign is_set = grp == CTDP_GRP_QUICK_SET && opword_r[7:6] == 2'h3
        && opword_r[5:3] != 3'h1;                                   // [RULE24]
    assign cls = ea_class(opword_r[5:3], opword_r[2:0]);
    // Mode 111 sub-code 100 with the SR permission stands for status register use
    logic imm_code;
    logic [1:0] combo;
    assign imm_code = opword_r[5:3] == 3'h7 && opword_r[2:0] == 3'h4;
    assign sr_mode = imm_code && sr_ok_r;
    // The immediate code doubles as status register use, so it is legal only when permitted
    assign ea_legal = (cls != 4'h0 && !imm_code) || sr_mode;        // [RULE14]
    // Combined categories: {data alterable, alterable memory}
    assign combo = {cls[3] && cls[0], cls[2] && cls[0]};            // [RULE10]
    assign ea_reg = (opword_r[5:3] != 3'h7) ? opword_r[2:0] : 3'h0; // [RULE11]
    assign ea_sub = (opword_r[5:3] == 3'h7) ? opword_r[2:0] : 3'h0; // [RULE12]
    assign set_byte = cond_ok ? 8'hff : 8'h00;                      // [RULE22]

    always_comb begin
        if (move_r) begin
            case (opword_r[13:12])                                  // [RULE21]
                2'h1: sz_code = CTDP_SZ_BYTE;
                2'h2: sz_code = CTDP_SZ_LONG;
                2'h3: sz_code = CTDP_SZ_WORD;
                default: sz_code = CTDP_SZ_OTHER;
            endcase
        end else begin
            sz_code = opword_r[7:6];                                // [RULE20]
        end
    end

    // ---------------------------------------------------------------
    // Prefetch queue
    // ---------------------------------------------------------------
    ctdp_pf_t pf_r;
    logic [15:0] ird_r;
    logic [15:0] irc_r;
    logic [31:0] pc_r;
    logic [15:0] fetch_cnt_r;
    logic [1:0] need_r;

    // Consumes act only with the queue full and no request pending; any other consume is ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pf_r <= CTDP_PF_EMPTY;
            ird_r <= CTDP_WORD_RST;
            irc_r <= CTDP_WORD_RST;
            pc_r <= CTDP_PC_RST;
            fetch_cnt_r <= 16'h0000;
            need_r <= 2'h2;
            ifetch_req_o <= 1'b0;
            ifetch_adr_o <= CTDP_PC_RST;
        end else if (flush_pulse) begin
            pf_r <= CTDP_PF_EMPTY;                                  // [RULE18]
            need_r <= 2'h2;                                         // [RULE18]
            ifetch_req_o <= 1'b0;
        end else if (ifetch_req_o) begin
            if (ifetch_ack_i) begin
                ifetch_req_o <= 1'b0;
                pc_r <= ifetch_adr_o;                               // [RULE19]
                fetch_cnt_r <= fetch_cnt_r + 16'h0001;
                case (pf_r)
                    CTDP_PF_EMPTY: begin
                        ird_r <= ifetch_dat_i;
                        pf_r <= CTDP_PF_ONE;
                    end
                    default: begin
                        irc_r <= ifetch_dat_i;                      // [RULE15]
                        pf_r <= CTDP_PF_FULL;
                    end
                endcase
            end
        end else if (ext_pulse && pf_r == CTDP_PF_FULL) begin
            pf_r <= CTDP_PF_ONE;                                    // [RULE16]
            ifetch_req_o <= 1'b1;
            ifetch_adr_o <= pc_r + 32'h2;
        end else if (next_pulse && pf_r == CTDP_PF_FULL) begin
            ird_r <= irc_r;                                         // [RULE17]
            pf_r <= CTDP_PF_ONE;
            ifetch_req_o <= 1'b1;
            ifetch_adr_o <= pc_r + 32'h2;
        end else if (need_r != 2'h0) begin
            need_r <= need_r - 2'h1;
            ifetch_req_o <= 1'b1;
            ifetch_adr_o <= (pf_r == CTDP_PF_EMPTY && need_r == 2'h2) ? pc_r : pc_r + 32'h2;
        end
    end

    // ---------------------------------------------------------------
    // Wishbone slave, single-cycle ack
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_hit;
            dat_o <= 32'h0000_0000;
            if (bus_hit && !we_i) begin
                case (adr_i)
                    CTDP_REG_CTRL: dat_o <= {26'h0, move_r, sr_ok_r, 4'h0};
                    CTDP_REG_FLAGS: dat_o <= {27'h0, flags_r};
                    CTDP_REG_OPWORD: dat_o <= {16'h0, opword_r};
                    CTDP_REG_COND: dat_o <= {12'h0, is_branch, is_set, ea_legal,
                        carry_in_r, set_byte, 7'h0, cond_ok};
                    CTDP_REG_EA: dat_o <= {16'h0, sz_code, ea_sub, ea_reg, 2'h0, combo, cls};
                    CTDP_REG_RESULT: dat_o <= result_r;
                    CTDP_REG_PFQ: dat_o <= {14'h0, pf_r, irc_r};
                    CTDP_REG_PC: dat_o <= pc_r;
                    CTDP_REG_IWORD: dat_o <= {16'h0, ird_r};
                    CTDP_REG_FETCHCNT: dat_o <= {16'h0, fetch_cnt_r};
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_cond_true_code: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
        opword_r[11:8] == 4'h0 |-> cond_ok) else $error("code 0 not true");
    a_cond_false_code: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
        opword_r[11:8] == 4'h1 |-> !cond_ok) else $error("code 1 not false");
    a_cond_equal: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
        opword_r[11:8] == 4'h7 |-> cond_ok == flags_r[CTDP_F_Z]) else $error("equal wrong");
    a_cond_signed_ge: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
        opword_r[11:8] == 4'hc |-> cond_ok == (flags_r[CTDP_F_N] == flags_r[CTDP_F_V]))
        else $error("ge wrong");
    a_flag_update: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
        upd_pulse |=> flags_r[CTDP_F_Z] == ($past(result_r) == 32'h0)
        && flags_r[CTDP_F_X] == $past(carry_in_r)) else $error("flag update wrong");
    a_set_byte: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE22]
        is_set && opword_r[11:8] == 4'h7 |-> set_byte == {8{flags_r[CTDP_F_Z]}})
        else $error("set byte wrong");
    a_imm_class: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
        opword_r[5:0] == 6'h3c |-> cls == 4'b1100) else $error("immediate class wrong");
    a_refill_fetch: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
        ext_pulse && pf_r == CTDP_PF_FULL && !ifetch_req_o && !flush_pulse
        |=> ifetch_req_o && ifetch_adr_o == $past(pc_r) + 32'h2) else $error("no refill");
    a_flush_clears: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE18]
        flush_pulse |=> pf_r == CTDP_PF_EMPTY && !ifetch_req_o) else $error("flush failed");
    a_pc_tracks: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE19]
        ifetch_req_o && ifetch_ack_i && !flush_pulse |=> pc_r == $past(ifetch_adr_o))
        else $error("pc not last fetch");
    a_cond_high: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
        opword_r[11:8] == 4'h2 |-> cond_ok == !(flags_r[CTDP_F_C] || flags_r[CTDP_F_Z]))
        else $error("high wrong");
    a_cond_le: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
        opword_r[11:8] == 4'hf
        |-> cond_ok == (flags_r[CTDP_F_Z] || flags_r[CTDP_F_N] != flags_r[CTDP_F_V]))
        else $error("le wrong");
    a_sr_permit: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
        opword_r[5:0] == 6'h3c |-> ea_legal == sr_ok_r) else $error("sr permit wrong");
    a_combined_cat: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
        opword_r[5:3] == 3'h0 |-> combo == 2'b10) else $error("combined category wrong");
    a_move_size: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE21]
        move_r && opword_r[13:12] == 2'h3 |-> sz_code == CTDP_SZ_WORD)
        else $error("move size wrong");
    a_next_shift: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE17]
        next_pulse && pf_r == CTDP_PF_FULL && !ifetch_req_o && !flush_pulse && !ext_pulse
        |=> ird_r == $past(irc_r) && ifetch_req_o) else $error("next word not taken");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack longer than one cycle");
endmodule

//--- verification/ctdp_imem.sv
module ctdp_imem (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] delay_i,
    output logic ack_o,
    output logic [15:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_r;
    // ---------------------------------------------------------------
    // Instruction memory: word content derived from its address
    // ---------------------------------------------------------------
    // Outside an answer the data line toggles, so a stale word never looks valid
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_r <= 4'h0;
            ack_o <= 1'b0;
            dat_o <= 16'hffff;
        end else if (req_i && !ack_o && wait_r >= delay_i) begin
            wait_r <= 4'h0;
            ack_o <= 1'b1;
            dat_o <= adr_i[15:0] ^ 16'h9c00;
        end else begin
            wait_r <= (req_i && !ack_o) ? wait_r + 4'h1 : 4'h0;
            ack_o <= 1'b0;
            dat_o <= ~dat_o;
        end
    end
endmodule

//--- verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ctdp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic we_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o;
    logic ifetch_req_o;
    logic [31:0] ifetch_adr_o;
    logic ifetch_ack_i;
    logic [15:0] ifetch_dat_i;
    logic [3:0] mem_delay = 4'h0;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    ctdp_core ctdp_core_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
        .ifetch_req_o(ifetch_req_o), .ifetch_adr_o(ifetch_adr_o), .ifetch_ack_i(ifetch_ack_i),
        .ifetch_dat_i(ifetch_dat_i));
    ctdp_imem ctdp_imem_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(ifetch_req_o),
        .adr_i(ifetch_adr_o), .delay_i(mem_delay), .ack_o(ifetch_ack_i), .dat_o(ifetch_dat_i));

    // ---------------------------------------------------------------
    // Bus access and comparison
    // ---------------------------------------------------------------
    task automatic end_sim;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Ack is sampled at the rising edge; read data is taken and the request dropped there
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        samples_checked++;
        if ((got & m) !== (exp & m)) begin
            num_errors++;
            $display("Error at %0t: read %h, expected %h", $time, got & m, exp & m);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] q;
        rd(a, q);
        check(q, exp, m);
    endtask

    // Consume and next-instruction actions are refused until the queue is full again, so wait for that
    task automatic settle;
        logic [31:0] q;
        for (int i = 0; i < 40; i++) begin
            rd(CTDP_REG_PFQ, q);
            if (q[17:16] === 2'b11 && ifetch_req_o === 1'b0) break;
        end
    endtask

    task automatic pf_check(input logic [15:0] iw, input logic [15:0] sw, input int pc,
                            input int cnt);
        settle();
        rd_check(CTDP_REG_IWORD, {16'h0, iw}, 32'hffff);
        rd_check(CTDP_REG_PFQ, {14'h0, 2'b11, sw}, 32'h3ffff);
        rd_check(CTDP_REG_PC, 32'(pc), 32'hffff_ffff);
        rd_check(CTDP_REG_FETCHCNT, 32'(cnt), 32'hffff_ffff);
    endtask

    function automatic logic cond_exp(input logic [3:0] c, input logic [3:0] f);
        logic [15:0] t;
        t = {f[2] | (f[3] ^ f[1]), ~f[2] & ~(f[3] ^ f[1]), f[3] ^ f[1], ~(f[3] ^ f[1]),
             f[3], ~f[3], f[1], ~f[1], f[2], ~f[2], f[0], ~f[0], f[0] | f[2],
             ~f[0] & ~f[2], 1'b0, 1'b1};
        return t[c];
    endfunction

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic test_bus;
        rd_check(CTDP_REG_FLAGS, {27'h0, CTDP_FLAGS_RST}, 32'h1f);
        wr(8'h40, 32'hdead_beef);
        rd_check(8'h40, 32'h0, 32'hffff_ffff);
    endtask

    task automatic test_prefetch;
        pf_check(16'h9c00, 16'h9c02, 2, 2);
        wr(CTDP_REG_CTRL, 32'h1 << CTDP_CTRL_CONSUME_EXT);
        pf_check(16'h9c00, 16'h9c04, 4, 3);
        mem_delay <= 4'h3;
        wr(CTDP_REG_CTRL, 32'h1 << CTDP_CTRL_NEXT_INSTR);
        // Refill still pending: this consume must be ignored
        wr(CTDP_REG_CTRL, 32'h1 << CTDP_CTRL_CONSUME_EXT);
        pf_check(16'h9c04, 16'h9c06, 6, 4);
        wr(CTDP_REG_CTRL, 32'h1 << CTDP_CTRL_FLUSH);
        pf_check(16'h9c06, 16'h9c08, 8, 6);
        mem_delay <= 4'h0;
    endtask

    task automatic test_cond;
        logic [3:0] grp;
        logic t;
        for (int k = 0; k < 16; k++) begin
            wr(CTDP_REG_FLAGS, {27'h0, 1'b1, 4'(k)});
            for (int c = 0; c < 16; c++) begin
                grp = c[0] ? CTDP_GRP_BRANCH : CTDP_GRP_QUICK_SET;
                t = cond_exp(4'(c), 4'(k));
                wr(CTDP_REG_OPWORD, {16'h0, grp, 4'(c), 8'hc0});
                rd_check(CTDP_REG_COND, {12'h0, c[0], ~c[0], 2'b00, {8{t}}, 7'h0, t},
                         32'h000c_ff01);
            end
            rd_check(CTDP_REG_FLAGS, {27'h0, 1'b1, 4'(k)}, 32'h1f);
        end
    endtask

    task automatic test_flag_update;
        logic [31:0] r;
        logic ci;
        for (int i = 0; i < 4; i++) begin
            r = (i == 1) ? 32'h8000_0000 : (i == 3) ? 32'hffff_ffff : 32'(i);
            ci = ~i[0];
            wr(CTDP_REG_FLAGS, 32'h02);
            wr(CTDP_REG_RESULT, r);
            wr(CTDP_REG_COND, {23'h0, ci, 8'h00});
            wr(CTDP_REG_CTRL, 32'h1 << CTDP_CTRL_FLAG_UPD);
            rd_check(CTDP_REG_FLAGS, {27'h0, ci, r[31], r == 32'h0, 1'b0, ci}, 32'h1f);
            rd_check(CTDP_REG_COND, {15'h0, ci, 16'h0}, 32'h1_0000);
        end
    endtask

    task automatic test_ea;
        logic [2:0] m;
        logic [2:0] g;
        logic [3:0] cls;
        logic [31:0] msk;
        wr(CTDP_REG_CTRL, 32'h0);
        for (int i = 0; i < 64; i++) begin
            m = 3'(i >> 3);
            g = 3'(i);
            cls = (m == 3'h0) ? 4'h9 : (m == 3'h1) ? 4'h1 : (m == 3'h3 || m == 3'h4) ? 4'hd :
                  (m != 3'h7 || g < 3'h2) ? 4'hf : (g < 3'h4) ? 4'he : (g == 3'h4) ? 4'hc : 4'h0;
            msk = (m != 3'h7) ? 32'hc70f : (g > 3'h4) ? 32'hc00f : 32'hf80f;
            wr(CTDP_REG_OPWORD, {24'h0, 2'(i), 6'(i)});
            rd_check(CTDP_REG_EA, {16'h0, 2'(i), g, g, 2'h0, cls[3] & cls[0], cls[2] & cls[0], cls},
                     msk | 32'h30);
            rd_check(CTDP_REG_COND, {14'h0, m != 3'h7 || g < 3'h4, 17'h0}, 32'h2_0000);
        end
        wr(CTDP_REG_CTRL, 32'h1 << CTDP_CTRL_SR_OK);
        rd_check(CTDP_REG_CTRL, 32'h10, 32'h30);
        wr(CTDP_REG_OPWORD, 32'h3c);
        rd_check(CTDP_REG_COND, 32'h2_0000, 32'h2_0000);
        wr(CTDP_REG_CTRL, 32'h1 << CTDP_CTRL_MOVE);
        rd_check(CTDP_REG_CTRL, 32'h20, 32'h30);
        for (int j = 1; j < 4; j++) begin
            wr(CTDP_REG_OPWORD, {18'h0, 2'(j), 12'h0});
            rd_check(CTDP_REG_EA, {16'h0, (j == 1) ? 2'h0 : (j == 2) ? 2'h2 : 2'h1, 14'h0},
                     32'hc000);
        end
    endtask

    // ---------------------------------------------------------------
    // Clock, reset, sequence and hang guard
    // ---------------------------------------------------------------
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        test_bus();
        test_prefetch();
        test_cond();
        test_flag_update();
        test_ea();
        end_sim();
    end
endmodule
